// ===== src/eep_defs.vh
`ifndef EEP_DEFS_VH
`define EEP_DEFS_VH

// select byte layout
`define EEP_TYPE_HI 7
`define EEP_TYPE_LO 4
`define EEP_TYPE_ARRAY 4'ha
`define EEP_TYPE_PAGE 4'hb
`define EEP_CE_HI_BIT 3
`define EEP_CE_LO_BIT 2
`define EEP_TOP_BIT 1
`define EEP_RW_BIT 0

// address and data byte layout
`define EEP_LOCK_SEL_BIT 7
`define EEP_LOCK_DATA_BIT 1

// array geometry
`define EEP_PAGES 32
`define EEP_PAGE_BYTES 16
`define EEP_ADDR_W 9
`define EEP_OFS_W 4

// bit slot counter: rising clock edges seen so far in the byte
`define EEP_LAST_BIT 4'h8
`define EEP_ACK_SLOT 4'h9
`define EEP_FIRST_BIT 4'h1

// write cycle timing
`define EEP_CLK_NS 10
`define EEP_T_WRITE_NS 100000
`define EEP_T_WRITE_CYC (`EEP_T_WRITE_NS / `EEP_CLK_NS)

`endif

// ===== src/eep_sync.v
`timescale 1ns/1ps
`default_nettype none

module eep_sync #(
  parameter WIDTH = 5
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // asynchronous levels in, synchronised levels out
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;

  // two flops per pin; the first is read only by the second
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge mclk) begin
        if (rst) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
        end else begin
          meta_q <= async_in[i];
          sync_q <= meta_q;
        end
      end
      assign sync_out[i] = sync_q;
    end
  endgenerate

endmodule

`default_nettype wire

// ===== src/eep_slave.v
// What this block does
// [RQ1] 512-byte array addressed as 32x16 pages
// [RQ2] extra 16-byte id page, permanently lockable
// [RQ3] strap pins set select bits 3, 2
// [RQ4] protect input high blocks all writes
// [RQ5] protected: ack select/address, nack data
// [RQ6] start is sda fall, scl high
// [RQ7] master sends start before every instruction
// [RQ8] stop is sda rise, scl high; ends
// [RQ9] stop after write starts write cycle
// [RQ10] sample sda on each scl rise
// [RQ11] master changes sda only while scl low
// [RQ12] transmitter releases; receiver acks ninth pulse
// [RQ13] sda open drain, never driven high
// [RQ14] slave only, never makes clock
// [RQ15] accept type 1010 or 1011 only
// [RQ16] respond only when chip field matches straps
// [RQ17] select msb first; bit1 top, bit0 rw
// [RQ18] rw bit one reads, zero writes
// [RQ19] mismatch releases bus until next start
// [RQ20] match acks select, then acks address
// [RQ21] array address: top bit plus address byte
// [RQ22] page: bit7 0 byte select, 1 lock
// [RQ23] write only on stop after data ack
// [RQ24] busy write cycle ignores bus requests
// [RQ25] multi-byte writes wrap within page
// [RQ26] lock needs data bit1; locked page nacks
// [RQ27] busy flag for write cycle, gates bus
`timescale 1ns/1ps
`default_nettype none
`include "eep_defs.vh"

module eep_slave #(
  parameter T_WRITE_CYC = `EEP_T_WRITE_CYC,
  parameter PAGES = `EEP_PAGES,
  parameter PAGE_BYTES = `EEP_PAGE_BYTES
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // two-wire bus pins
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // strap and protect pins
  input wire chip_enable_high_strap,
  input wire chip_enable_low_strap,
  input wire write_protect_input,
  // accepted data bytes to the storage
  output reg byte_valid,
  output reg byte_to_page,
  output reg [`EEP_ADDR_W-1:0] byte_addr,
  output reg [7:0] byte_data,
  // write cycle and status
  output reg write_start,
  output wire write_busy,
  output wire page_locked,
  output wire read_request
);

  // ----------------------------------------------------------------
  // state codes
  // ----------------------------------------------------------------
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_SEL = 5'b00010;
  localparam [4:0] S_ADDR = 5'b00100;
  localparam [4:0] S_DATA = 5'b01000;
  localparam [4:0] S_SKIP = 5'b10000;

  localparam CNT_W = 24;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [4:0] pins_s;
  wire scl_s;
  wire sda_s;
  wire ce_hi_s;
  wire ce_lo_s;
  wire wp_s;

  // floating straps are pulled low outside; we just sample them
  eep_sync #(
    .WIDTH(5)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in({scl_in, sda_in, chip_enable_high_strap,
      chip_enable_low_strap, write_protect_input}),
    .sync_out(pins_s)
  );

  assign scl_s = pins_s[4];
  assign sda_s = pins_s[3];
  assign ce_hi_s = pins_s[2];
  assign ce_lo_s = pins_s[1];
  assign wp_s = pins_s[0];

  // ----------------------------------------------------------------
  // bus condition detection
  // ----------------------------------------------------------------
  reg scl_prev_q;
  reg sda_prev_q;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;

  // previous levels for edge finding
  always @(posedge mclk) begin
    if (rst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  // data sampled at clock rise, moved on at clock fall
  assign scl_rise = scl_s & ~scl_prev_q; // see [RQ10]
  assign scl_fall = ~scl_s & scl_prev_q;
  // sda edges with scl held high are framing, not data
  assign start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s; // see [RQ6]
  assign stop_cond = scl_s & scl_prev_q & ~sda_prev_q & sda_s; // see [RQ8]

  // ----------------------------------------------------------------
  // protocol registers
  // ----------------------------------------------------------------
  reg [4:0] state_q;
  reg [3:0] bit_q;
  reg [7:0] shift_q;
  reg ack_q;
  reg to_page_q;
  reg top_q;
  reg rd_q;
  reg lock_cmd_q;
  reg lock_data_q;
  reg locked_q;
  reg wr_pend_q;
  reg [`EEP_ADDR_W-1:0] addr_q;
  reg [CNT_W-1:0] busy_cnt_q;
  reg busy_q;

  wire [7:0] byte_in;
  wire type_ok;
  wire ce_ok;
  wire sel_ok;
  wire data_ok;
  wire byte_done;
  wire ack_done;
  wire write_go;

  // byte as it stands after the eighth rising edge
  assign byte_in = shift_q;

  // only the two type codes are answered
  assign type_ok = (byte_in[`EEP_TYPE_HI:`EEP_TYPE_LO] ==
    `EEP_TYPE_ARRAY) ||
    (byte_in[`EEP_TYPE_HI:`EEP_TYPE_LO] ==
    `EEP_TYPE_PAGE); // see [RQ15]

  // received chip field must equal the strapped pins
  assign ce_ok = (byte_in[`EEP_CE_HI_BIT] == ce_hi_s) &&
    (byte_in[`EEP_CE_LO_BIT] == ce_lo_s); // see [RQ3] see [RQ16]

  // a busy device stays silent so the master can poll
  assign sel_ok = type_ok & ce_ok & ~busy_q; // see [RQ24]

  // data bytes are refused when protected or page locked
  assign data_ok = ~wp_s &
    ~(to_page_q & locked_q); // see [RQ4] see [RQ5] see [RQ26]

  assign byte_done = scl_fall & (bit_q == `EEP_LAST_BIT);
  assign ack_done = scl_fall & (bit_q == `EEP_ACK_SLOT);

  // only a stop in the slot right after a data ack commits
  assign write_go = stop_cond & state_q[3] & wr_pend_q &
    (bit_q == `EEP_FIRST_BIT); // see [RQ9] see [RQ23]

  // ----------------------------------------------------------------
  // bit slot counter and shifter
  // ----------------------------------------------------------------
  // nine slots per byte; the ninth is the acknowledge
  always @(posedge mclk) begin
    if (rst) begin
      bit_q <= 4'h0;
      shift_q <= 8'h00;
    end else if (start_cond & ~busy_q) begin
      bit_q <= 4'h0;
    end else if (scl_rise & (bit_q != `EEP_ACK_SLOT)) begin
      shift_q <= {shift_q[6:0], sda_s}; // see [RQ10] see [RQ17]
      bit_q <= bit_q + 4'h1;
    end else if (ack_done) begin
      bit_q <= 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // transfer state machine
  // ----------------------------------------------------------------
  // start is ignored while busy; a stop always ends the talk
  always @(posedge mclk) begin
    if (rst) begin
      state_q <= S_IDLE;
      ack_q <= 1'b0;
      to_page_q <= 1'b0;
      top_q <= 1'b0;
      rd_q <= 1'b0;
      lock_cmd_q <= 1'b0;
      lock_data_q <= 1'b0;
      wr_pend_q <= 1'b0;
      addr_q <= {`EEP_ADDR_W{1'b0}};
    end else if (start_cond & ~busy_q) begin
      state_q <= S_SEL; // see [RQ6]
      ack_q <= 1'b0;
      wr_pend_q <= 1'b0;
      lock_data_q <= 1'b0;
    end else if (stop_cond) begin
      state_q <= S_IDLE; // see [RQ8]
      ack_q <= 1'b0;
      wr_pend_q <= 1'b0;
    end else begin
      case (state_q)
        S_SEL: begin
          if (byte_done) begin
            if (sel_ok) begin
              ack_q <= 1'b1; // see [RQ20]
              to_page_q <= byte_in[`EEP_TYPE_LO];
              top_q <= byte_in[`EEP_TOP_BIT]; // see [RQ17]
              rd_q <= byte_in[`EEP_RW_BIT]; // see [RQ18]
            end else begin
              state_q <= S_SKIP; // see [RQ19]
            end
          end else if (ack_done) begin
            ack_q <= 1'b0; // see [RQ12]
            // reads are served by the storage side
            state_q <= rd_q ? S_SKIP : S_ADDR;
          end
        end
        S_ADDR: begin
          if (byte_done) begin
            ack_q <= 1'b1; // see [RQ5] see [RQ20]
            if (to_page_q) begin
              lock_cmd_q <= byte_in[`EEP_LOCK_SEL_BIT]; // see [RQ22]
              addr_q <= {{(`EEP_ADDR_W-`EEP_OFS_W){1'b0}},
                byte_in[`EEP_OFS_W-1:0]}; // see [RQ22]
            end else begin
              lock_cmd_q <= 1'b0;
              addr_q <= {top_q, byte_in}; // see [RQ21]
            end
          end else if (ack_done) begin
            ack_q <= 1'b0;
            state_q <= S_DATA;
          end
        end
        S_DATA: begin
          if (byte_done) begin
            ack_q <= data_ok; // see [RQ5]
            if (data_ok) begin
              wr_pend_q <= 1'b1;
              if (lock_cmd_q) begin
                lock_data_q <= byte_in[`EEP_LOCK_DATA_BIT]; // see [RQ26]
              end
            end
          end else if (ack_done) begin
            ack_q <= 1'b0;
            if (ack_q) begin
              // offset wraps, page bits stay put
              addr_q[`EEP_OFS_W-1:0] <=
                addr_q[`EEP_OFS_W-1:0] + 4'h1; // see [RQ25]
            end
          end
        end
        S_SKIP: begin
          ack_q <= 1'b0; // see [RQ19]
        end
        default: begin
          ack_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // byte hand-off to the storage
  // ----------------------------------------------------------------
  // one pulse per accepted data byte; lock bytes are not stored
  always @(posedge mclk) begin
    if (rst) begin
      byte_valid <= 1'b0;
      byte_to_page <= 1'b0;
      byte_addr <= {`EEP_ADDR_W{1'b0}};
      byte_data <= 8'h00;
    end else begin
      byte_valid <= byte_done & state_q[3] & data_ok &
        ~lock_cmd_q & ~stop_cond & ~(start_cond & ~busy_q);
      if (byte_done & state_q[3]) begin
        byte_to_page <= to_page_q; // see [RQ2]
        byte_addr <= addr_q; // see [RQ1]
        byte_data <= byte_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // write cycle timer and page lock
  // ----------------------------------------------------------------
  // the lock lives until reset; storage keeps it across power
  always @(posedge mclk) begin
    if (rst) begin
      write_start <= 1'b0;
      busy_q <= 1'b0;
      busy_cnt_q <= {CNT_W{1'b0}};
      locked_q <= 1'b0;
    end else begin
      write_start <= write_go;
      if (write_go) begin
        busy_q <= 1'b1; // see [RQ27]
        busy_cnt_q <= T_WRITE_CYC[CNT_W-1:0] - 24'h00_0001;
        if (lock_cmd_q & lock_data_q) begin
          locked_q <= 1'b1; // see [RQ2] see [RQ26]
        end
      end else if (busy_q) begin
        if (busy_cnt_q == {CNT_W{1'b0}}) begin
          busy_q <= 1'b0; // see [RQ27]
        end else begin
          busy_cnt_q <= busy_cnt_q - 24'h00_0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // pin only ever pulls low; no clock is driven anywhere
  assign sda_out = 1'b0; // see [RQ13] see [RQ14]
  assign sda_oe = ack_q & ~busy_q; // see [RQ12] see [RQ24]
  assign write_busy = busy_q;
  assign page_locked = locked_q;
  // a matched read select, for the storage side's read path
  assign read_request = rd_q & state_q[1] & ack_q;

endmodule

`default_nettype wire

// ===== bench/eep_slave_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "eep_defs.vh"

module eep_slave_properties #(
  parameter T_WRITE_CYC = `EEP_T_WRITE_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // bus pins and straps
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_protect_input,
  // outputs under watch
  input wire logic byte_valid,
  input wire logic byte_to_page,
  input wire logic [`EEP_ADDR_W-1:0] byte_addr,
  input wire logic write_start,
  input wire logic write_busy,
  input wire logic page_locked
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // busy run is too long to unroll, so count it instead
  logic [15:0] busy_q;
  logic [15:0] busy_d;
  always_comb busy_d = write_busy ? busy_q + 16'h0001 : 16'h0000;
  always_ff @(posedge mclk) begin
    if (rst) busy_q <= 16'h0000;
    else busy_q <= busy_d;
  end

  sequence s_wp_held;
    write_protect_input [*8];
  endsequence
  sequence s_busy_run;
    write_busy [*8];
  endsequence

  a_busy_follows: assert property (write_start |=> s_busy_run)
    else $error("busy missing after trigger");
  a_busy_length: assert property (
    $fell(write_busy) |-> busy_q == T_WRITE_CYC)
    else $error("busy length off");
  a_busy_bound: assert property (
    write_busy |-> busy_q < T_WRITE_CYC)
    else $error("busy overran");
  a_busy_silent: assert property (write_busy |-> !sda_oe)
    else $error("ack while busy");
  // trigger and busy rise together; no second trigger inside the run
  a_busy_no_trig: assert property (
    write_busy && $past(write_busy) |-> !write_start)
    else $error("trigger while busy");
  a_open_drain: assert property (sda_oe |-> !sda_out)
    else $error("sda driven high");
  a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("ack edge with scl high");
  a_stop_levels: assert property (
    write_start |-> scl_in && sda_in)
    else $error("trigger without stop");
  a_valid_pulse: assert property (byte_valid |=> !byte_valid)
    else $error("byte pulse too long");
  a_protect_data: assert property (s_wp_held |-> !byte_valid)
    else $error("byte taken while protected");
  a_page_offset: assert property (
    byte_valid && byte_to_page |-> byte_addr[8:4] == 5'h00)
    else $error("page offset too wide");
  a_lock_sticky: assert property (page_locked |=> page_locked)
    else $error("lock dropped");
  a_lock_at_trig: assert property (
    $rose(page_locked) |-> write_start || $past(write_start))
    else $error("lock without trigger");
endmodule

bind eep_slave eep_slave_properties #(.T_WRITE_CYC(T_WRITE_CYC)) u_props (
  .mclk(mclk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe),
  .write_protect_input(write_protect_input), .byte_valid(byte_valid),
  .byte_to_page(byte_to_page), .byte_addr(byte_addr),
  .write_start(write_start), .write_busy(write_busy),
  .page_locked(page_locked)
);

`default_nettype wire

// ===== bench/eep_master.sv
`timescale 1ns/1ps
`default_nettype none

module eep_master (
  // clock
  input wire logic mclk,
  // bus lines, wired-and with pull-up outside
  output var logic scl,
  output var logic sda_low,
  input wire logic sda_bus,
  input wire logic probe
);
  // idle bus: clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // sda falls while scl high; also serves as restart
  task automatic start();
    sda_low <= 1'b0;
    tk(4);
    scl <= 1'b1;
    tk(8);
    sda_low <= 1'b1;
    tk(8);
    scl <= 1'b0;
    tk(4);
  endtask

  // data moves only with scl low, msb first
  task automatic put_byte(input logic [7:0] b, output logic ack,
                          output logic pr);
    for (int i = 7; i >= 0; i--) begin
      sda_low <= ~b[i];
      tk(4);
      scl <= 1'b1;
      tk(8);
      scl <= 1'b0;
      tk(4);
    end
    // release for the ninth pulse
    sda_low <= 1'b0;
    tk(4);
    scl <= 1'b1;
    tk(4);
    ack = ~sda_bus;
    pr = probe;
    tk(4);
    scl <= 1'b0;
    tk(4);
  endtask

  // top n bits of a byte only, so a stop can land mid-byte
  task automatic put_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      sda_low <= ~b[i];
      tk(4);
      scl <= 1'b1;
      tk(8);
      scl <= 1'b0;
      tk(4);
    end
  endtask

  // one clock in the tenth slot with sda low, then sda rises
  task automatic stop();
    sda_low <= 1'b1;
    tk(4);
    scl <= 1'b1;
    tk(8);
    sda_low <= 1'b0;
    tk(8);
  endtask
endmodule

`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int T_WR = 400;
  // trigger note: a page byte can never carry this address
  localparam logic [17:0] TRIG = 18'h3_fe00;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce_hi = 1'b0;
  logic ce_lo = 1'b0;
  logic wp = 1'b0;
  logic scl, sda_low;
  wire sda_bus, sda_out, sda_oe, byte_valid, byte_to_page;
  wire write_start, write_busy, page_locked, read_request;
  wire [8:0] byte_addr;
  wire [7:0] byte_data;
  logic [17:0] exp_q[$];
  int bad_count, checks;
  logic [1:0] ce;
  logic [8:0] a;
  logic [7:0] d;

  always #5 mclk = ~mclk;
  assign sda_bus = ~(sda_low | (sda_oe & ~sda_out));

  eep_slave #(.T_WRITE_CYC(T_WR)) dut_u (
    .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda_bus),
    .sda_out(sda_out), .sda_oe(sda_oe), .chip_enable_high_strap(ce_hi),
    .chip_enable_low_strap(ce_lo), .write_protect_input(wp),
    .byte_valid(byte_valid), .byte_to_page(byte_to_page),
    .byte_addr(byte_addr), .byte_data(byte_data),
    .write_start(write_start), .write_busy(write_busy),
    .page_locked(page_locked), .read_request(read_request));

  eep_master m_u (.mclk(mclk), .scl(scl), .sda_low(sda_low),
    .sda_bus(sda_bus), .probe(read_request));

  task automatic check(input logic [17:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic xfer(input logic [7:0] b, input logic ea, ep);
    logic ak;
    logic rq;
    m_u.put_byte(b, ak, rq);
    check({17'h0, ak}, {17'h0, ea}, "ack");
    check({17'h0, rq}, {17'h0, ep}, "read flag");
  endtask

  task automatic sel_adr(input logic [7:0] s, ad);
    m_u.start();
    xfer(s, 1'b1, 1'b0);
    xfer(ad, 1'b1, 1'b0);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 1000 && write_busy !== 1'b0; i++) @(posedge mclk);
    if (write_busy !== 1'b0) begin
      bad_count++;
      give_verdict();
    end
  endtask

  // each pulse takes the oldest note; none left means a stray pulse
  always @(posedge mclk) begin
    if (byte_valid === 1'b1)
      check({byte_to_page, byte_addr, byte_data},
        exp_q.size() ? exp_q.pop_front() : 18'h3_ffff, "byte");
    if (write_start === 1'b1)
      check(TRIG, exp_q.size() ? exp_q.pop_front() : 18'h3_ffff,
        "trigger");
  end

  initial begin
    void'($urandom(92121));
    repeat (10) @(posedge mclk);
    ce = 2'($urandom);
    ce_hi <= ce[1];
    ce_lo <= ce[0];
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    // array byte, then a select while the write runs
    a = 9'($urandom);
    d = 8'($urandom);
    sel_adr({4'b1010, ce, a[8], 1'b0}, a[7:0]);
    exp_q.push_back({1'b0, a, d});
    exp_q.push_back(TRIG);
    xfer(d, 1'b1, 1'b0);
    m_u.stop();
    m_u.start();
    xfer({4'b1010, ce, 2'b00}, 1'b0, 1'b0);
    m_u.stop();
    wait_idle();
    $display("test 1 done");
    // every type code against every chip code
    for (int t = 0; t < 16; t++) begin
      for (int c = 0; c < 4; c++) begin
        m_u.start();
        xfer({4'(t), 2'(c), 2'b00}, (t == 10 || t == 11) && c == ce,
          1'b0);
        m_u.stop();
      end
    end
    $display("test 2 done");
    // seventeen bytes roll over inside one page
    a = 9'($urandom);
    sel_adr({4'b1010, ce, a[8], 1'b0}, a[7:0]);
    for (int i = 0; i < 17; i++) begin
      d = 8'($urandom);
      exp_q.push_back({1'b0, a[8:4], 4'(a[3:0] + i), d});
      xfer(d, 1'b1, 1'b0);
    end
    exp_q.push_back(TRIG);
    m_u.stop();
    wait_idle();
    $display("test 3 done");
    // stop in mid-byte: byte handed over, but no write cycle
    d = 8'($urandom);
    sel_adr({4'b1010, ce, 2'b00}, 8'h20);
    exp_q.push_back({1'b0, 9'h020, d});
    xfer(d, 1'b1, 1'b0);
    m_u.put_bits(8'h00, 3);
    m_u.stop();
    check({17'h0, write_busy}, 18'h0, "busy");
    // protected: header acked, data refused, no write
    wp <= 1'b1;
    sel_adr({4'b1010, ce, 2'b00}, 8'h00);
    xfer(8'h5a, 1'b0, 1'b0);
    m_u.stop();
    wp <= 1'b0;
    // read select is acked and flagged
    m_u.start();
    xfer({4'b1010, ce, 2'b01}, 1'b1, 1'b1);
    m_u.stop();
    $display("test 4 done");
    // id page byte, lock without and with the key bit
    a = 9'($urandom);
    d = 8'($urandom);
    sel_adr({4'b1011, ce, a[8], 1'b0}, {1'b0, a[6:0]});
    exp_q.push_back({1'b1, 5'h00, a[3:0], d});
    exp_q.push_back(TRIG);
    xfer(d, 1'b1, 1'b0);
    m_u.stop();
    wait_idle();
    for (int k = 0; k < 2; k++) begin
      sel_adr({4'b1011, ce, 2'b00}, {1'b1, a[6:0]});
      exp_q.push_back(TRIG);
      xfer({d[7:2], 1'(k), d[0]}, 1'b1, 1'b0);
      m_u.stop();
      wait_idle();
      check({17'h0, page_locked}, 18'(k), "locked");
    end
    sel_adr({4'b1011, ce, 2'b00}, 8'h03);
    xfer(d, 1'b0, 1'b0);
    m_u.stop();
    $display("test 5 done");
    check(18'(exp_q.size()), 18'h0, "notes left");
    give_verdict();
  end
endmodule

`default_nettype wire
